// ==== csrf_pkg.sv ====
`default_nettype none
package csrf_pkg;
  localparam int unsigned DATA_W     = 32;
  localparam int unsigned GPR_NUM    = 13;
  localparam logic [3:0] IDX_SP      = 4'hD;
  localparam logic [3:0] IDX_LINK    = 4'hE;
  localparam logic [3:0] IDX_PC      = 4'hF;
  localparam logic [31:0] VEC_STACK_ADDR = 32'h0000_0000;
  localparam logic [31:0] VEC_RESET_ADDR = 32'h0000_0004;
  localparam logic [31:0] STACK_WORD     = 32'h0000_0004;
  localparam int unsigned FLAG_N_BIT = 31;
  localparam int unsigned FLAG_Z_BIT = 30;
  localparam int unsigned FLAG_C_BIT = 29;
  localparam int unsigned FLAG_V_BIT = 28;
  localparam int unsigned STATE_BIT  = 24;
  localparam int unsigned EXC_MSB    = 5;
  localparam int unsigned SEL_BIT    = 1;
  localparam int unsigned MASK_BIT   = 0;
  localparam logic [5:0] EXC_THREAD  = 6'h00;
  localparam logic [5:0] EXC_NMI     = 6'h02;
  localparam logic [5:0] EXC_FAULT   = 6'h03;
  localparam logic [5:0] EXC_SVC     = 6'h0B;
  localparam logic [5:0] EXC_PEND    = 6'h0E;
  localparam logic [5:0] EXC_TICK    = 6'h0F;
  localparam logic [5:0] EXC_IRQ_LO  = 6'h10;
  localparam logic [5:0] EXC_IRQ_HI  = 6'h2F;
  localparam logic [31:0] FLAGS_MASK = 32'hF000_0000;
  localparam logic [31:0] EXC_MASK   = 32'h0000_003F;
  localparam int unsigned PRIO_LEVELS = 4;
  localparam logic [31:0] MASK_RESET  = 32'h0000_0000;
  localparam logic [31:0] SEL_RESET   = 32'h0000_0000;

  typedef enum logic [1:0] {CSRF_BOOT_SP, CSRF_BOOT_PC, CSRF_RUN} csrf_boot_t;

  // special-register selector for the move instructions
  typedef enum logic [3:0] {
    CSRF_SR_STATUS, CSRF_SR_FLAGS, CSRF_SR_EXC, CSRF_SR_STATE,
    CSRF_SR_EXC_STATE, CSRF_SR_FLAGS_EXC, CSRF_SR_FLAGS_STATE,
    CSRF_SR_MSP, CSRF_SR_PSP, CSRF_SR_MASK, CSRF_SR_SEL
  } csrf_sreg_t;

  typedef struct packed {
    logic       valid;
    logic [3:0] idx;
    logic [31:0] data;
  } csrf_gpw_t;

  typedef struct packed {
    logic       valid;
    csrf_sreg_t sel;
    logic [31:0] data;
  } csrf_srw_t;

  typedef struct packed {
    logic       n;
    logic       z;
    logic       c;
    logic       v;
  } csrf_flags_t;

  typedef struct packed {
    logic       enter;
    logic [5:0] num;
    logic [31:0] vector;
    logic       ret;
    logic       ret_to_thread;
    logic       ret_use_psp;
  } csrf_exc_t;
endpackage
`default_nettype wire

// ==== csrf_stack_adj.sv ====
`timescale 1ns/10ps
`default_nettype none
// banked stack pointer update: push, pop, or software load
module csrf_stack_adj
  import csrf_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        resetn,
  input  wire logic        clk_en,
  input  wire logic        sel,
  input  wire logic        boot_load,
  input  wire logic [31:0] boot_val,
  input  wire logic        push,
  input  wire logic        pop,
  input  wire logic        sw_load,
  input  wire logic [31:0] sw_val,
  output logic [31:0]      sp_q
);
  logic [31:0] sp_d;

  always_comb begin
    sp_d = sp_q;
    if (boot_load) begin
      sp_d = boot_val;
    end else if (sw_load) begin
      sp_d = {sw_val[31:2], 2'b00};
    end else if (sel && push) begin
      sp_d = sp_q - STACK_WORD;
    end else if (sel && pop) begin
      sp_d = sp_q + STACK_WORD;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      sp_q <= 32'h0000_0000;
    end else if (clk_en) begin
      sp_q <= sp_d;
    end
  end
endmodule
`default_nettype wire

// ==== csrf_core_state.sv ====
// What this block does
// RL1 - after reset the core runs in thread mode
// RL2 - exceptions run in handler mode; thread resumes after last exception
// RL3 - push decrements the active stack pointer then writes at new address
// RL4 - main and process stack pointers are separate registers
// RL5 - in thread mode select bit 1 picks process pointer, reset selects main
// RL6 - handler mode always uses the main stack pointer
// RL7 - reset loads main stack pointer from word at address zero
// RL8 - reset loads pc from address four; bit 0 goes to state bit 24
// RL9 - thirteen 32-bit general registers, undefined after reset
// RL10 - index 13 is active sp, 14 link register, 15 program counter
// RL11 - flags, exception and state views share one status word
// RL12 - software writes never change the exception number field
// RL13 - state bits read zero and ignore software writes
// RL14 - flags n z c v in bits 31 to 28, rest reserved
// RL15 - exception field bits 5:0 hold current exception code
// RL16 - configurable interrupts have exactly four priority levels
// RL17 - exception entry stacks caller context in hardware
// RL18 - interrupted load or store multiple restarts from the beginning
// RL19 - in handler mode select bit reads zero and ignores writes
// RL20 - mask bit 0 blocks activation of configurable priority exceptions
// RL21 - executing with state bit zero raises a fatal fault
// RL22 - entry writes exception number; return to thread clears it
// RL23 - process pointer changes only by software write or stacking
`timescale 1ns/10ps
`default_nettype none
module csrf_core_state
  import csrf_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        resetn,
  input  wire logic        clk_en,
  output logic             mem_rd_q,
  output logic [31:0]      mem_addr_q,
  input  wire logic        mem_rd_ok,
  input  wire logic [31:0] mem_rdata,
  input  wire csrf_gpw_t   gp_wr,
  input  wire logic [3:0]  gp_rd_idx,
  output logic [31:0]      gp_rd_data_q,
  input  wire logic        pc_load,
  input  wire logic [31:0] pc_val,
  input  wire logic        state_load,
  input  wire logic        state_val,
  input  wire logic        flags_wr,
  input  wire csrf_flags_t flags_val,
  input  wire csrf_srw_t   sr_wr,
  input  wire csrf_sreg_t  sr_rd_sel,
  output logic [31:0]      sr_rd_data_q,
  input  wire logic        stack_push,
  input  wire logic        stack_pop,
  input  wire csrf_exc_t   exc,
  input  wire logic        irq_req,
  input  wire logic [1:0]  irq_prio,
  input  wire logic        multi_busy,
  input  wire logic        exec_attempt,
  output logic             handler_mode_q,
  output logic [31:0]      active_sp_q,
  output logic [31:0]      pc_q,
  output logic             irq_accept_q,
  output logic [1:0]       irq_prio_q,
  output logic             multi_restart_q,
  output logic             stack_ctx_q,
  output logic             state_fault_q
);
  csrf_boot_t  boot_q;
  logic [31:0] gpr_q [GPR_NUM];
  logic [31:0] link_q;
  logic [31:0] msp_q;
  logic [31:0] psp_q;
  logic [3:0]  flags_q;
  logic [5:0]  exc_q;
  logic        state_q;
  logic        mask_q;
  logic        sel_q;
  logic        use_psp;
  logic [31:0] sp_now;
  logic        booting;
  logic        msp_boot;
  logic        msp_sw;
  logic        psp_sw;
  logic        sr_flags;
  logic        sr_mask;
  logic        sr_sel;
  logic        irq_ok;

  function automatic logic [31:0] status_view(input csrf_sreg_t s, input logic [3:0] f, input logic [5:0] e);
    logic [31:0] v;
    v = 32'h0000_0000;
    if (s == CSRF_SR_STATUS || s == CSRF_SR_FLAGS || s == CSRF_SR_FLAGS_EXC || s == CSRF_SR_FLAGS_STATE) begin
      v[FLAG_N_BIT:FLAG_V_BIT] = f; // RL11 RL14
    end
    if (s == CSRF_SR_STATUS || s == CSRF_SR_EXC || s == CSRF_SR_EXC_STATE || s == CSRF_SR_FLAGS_EXC) begin
      v[EXC_MSB:0] = e; // RL11 RL15
    end
    return v; // state bit never visible to software RL13
  endfunction

  function automatic logic writes_flags(input csrf_sreg_t s);
    return s == CSRF_SR_STATUS || s == CSRF_SR_FLAGS || s == CSRF_SR_FLAGS_EXC || s == CSRF_SR_FLAGS_STATE;
  endfunction

  assign booting  = (boot_q != CSRF_RUN);
  assign use_psp  = sel_q && !handler_mode_q; // RL5 RL6
  assign sp_now   = use_psp ? psp_q : msp_q;
  assign msp_boot = (boot_q == CSRF_BOOT_SP) && mem_rd_ok;
  assign msp_sw   = sr_wr.valid && sr_wr.sel == CSRF_SR_MSP;
  assign psp_sw   = sr_wr.valid && sr_wr.sel == CSRF_SR_PSP; // RL23
  assign sr_flags = sr_wr.valid && writes_flags(sr_wr.sel);
  assign sr_mask  = sr_wr.valid && sr_wr.sel == CSRF_SR_MASK;
  assign sr_sel   = sr_wr.valid && sr_wr.sel == CSRF_SR_SEL;
  assign irq_ok   = irq_req && !mask_q && !booting; // RL20

  // vector fetch sequence after reset
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      boot_q     <= CSRF_BOOT_SP;
      mem_rd_q   <= 1'b1;
      mem_addr_q <= VEC_STACK_ADDR;
    end else if (clk_en) begin
      case (boot_q)
        CSRF_BOOT_SP: begin
          if (mem_rd_ok) begin
            boot_q     <= CSRF_BOOT_PC;
            mem_addr_q <= VEC_RESET_ADDR; // RL8
          end
        end
        CSRF_BOOT_PC: begin
          if (mem_rd_ok) begin
            boot_q   <= CSRF_RUN;
            mem_rd_q <= 1'b0;
          end
        end
        default: begin
          mem_rd_q <= 1'b0;
        end
      endcase
    end
  end

  csrf_stack_adj u_msp (
    .ref_clk   (ref_clk),
    .resetn    (resetn),
    .clk_en    (clk_en),
    .sel       (!use_psp),
    .boot_load (msp_boot), // RL7
    .boot_val  (mem_rdata),
    .push      (stack_push && !booting), // RL3
    .pop       (stack_pop && !booting),
    .sw_load   (msp_sw),
    .sw_val    (sr_wr.data),
    .sp_q      (msp_q)
  );

  csrf_stack_adj u_psp (
    .ref_clk   (ref_clk),
    .resetn    (resetn),
    .clk_en    (clk_en),
    .sel       (use_psp), // RL4
    .boot_load (1'b0),
    .boot_val  (32'h0000_0000),
    .push      (stack_push && !booting), // RL3 RL23
    .pop       (stack_pop && !booting),
    .sw_load   (psp_sw),
    .sw_val    (sr_wr.data),
    .sp_q      (psp_q)
  );

  // general registers carry no reset
  always_ff @(posedge ref_clk) begin
    if (clk_en && gp_wr.valid && gp_wr.idx < IDX_SP) begin
      gpr_q[gp_wr.idx] <= gp_wr.data; // RL9
    end
  end

  always_ff @(posedge ref_clk) begin
    if (clk_en && gp_wr.valid && gp_wr.idx == IDX_LINK) begin
      link_q <= gp_wr.data; // RL10
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      pc_q <= 32'h0000_0000;
    end else if (clk_en) begin
      if (boot_q == CSRF_BOOT_PC && mem_rd_ok) begin
        pc_q <= {mem_rdata[31:1], 1'b0}; // RL8
      end else if (exc.enter) begin
        pc_q <= {exc.vector[31:1], 1'b0};
      end else if (pc_load) begin
        pc_q <= {pc_val[31:1], 1'b0};
      end else if (gp_wr.valid && gp_wr.idx == IDX_PC) begin
        pc_q <= {gp_wr.data[31:1], 1'b0}; // RL10
      end
    end
  end

  // state bit: from vectors or branch logic only, never from software
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= 1'b0;
    end else if (clk_en) begin
      if (boot_q == CSRF_BOOT_PC && mem_rd_ok) begin
        state_q <= mem_rdata[0]; // RL8
      end else if (exc.enter) begin
        state_q <= exc.vector[0];
      end else if (state_load) begin
        state_q <= state_val; // RL13
      end
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      flags_q <= 4'h0;
    end else if (clk_en) begin
      if (flags_wr) begin
        flags_q <= flags_val; // RL14
      end else if (sr_flags) begin
        flags_q <= sr_wr.data[FLAG_N_BIT:FLAG_V_BIT]; // RL11
      end
    end
  end

  // mode and exception number; software writes never reach here
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      handler_mode_q <= 1'b0; // RL1
      exc_q          <= EXC_THREAD;
    end else if (clk_en) begin
      if (exc.enter && !booting) begin
        handler_mode_q <= 1'b1; // RL2
        exc_q          <= exc.num; // RL22 RL12
      end else if (exc.ret && exc.ret_to_thread) begin
        handler_mode_q <= 1'b0; // RL2
        exc_q          <= EXC_THREAD; // RL22
      end
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      mask_q <= MASK_RESET[MASK_BIT];
    end else if (clk_en && sr_mask) begin
      mask_q <= sr_wr.data[MASK_BIT]; // RL20
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      sel_q <= SEL_RESET[SEL_BIT]; // RL5
    end else if (clk_en) begin
      if (exc.ret && exc.ret_to_thread) begin
        sel_q <= exc.ret_use_psp;
      end else if (sr_sel && !handler_mode_q) begin
        sel_q <= sr_wr.data[SEL_BIT]; // RL19
      end
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      gp_rd_data_q <= 32'h0000_0000;
    end else if (clk_en) begin
      if (gp_rd_idx == IDX_SP) begin
        gp_rd_data_q <= sp_now; // RL10
      end else if (gp_rd_idx == IDX_LINK) begin
        gp_rd_data_q <= link_q;
      end else if (gp_rd_idx == IDX_PC) begin
        gp_rd_data_q <= pc_q;
      end else begin
        gp_rd_data_q <= gpr_q[gp_rd_idx];
      end
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      sr_rd_data_q <= 32'h0000_0000;
    end else if (clk_en) begin
      if (sr_rd_sel == CSRF_SR_MSP) begin
        sr_rd_data_q <= msp_q;
      end else if (sr_rd_sel == CSRF_SR_PSP) begin
        sr_rd_data_q <= psp_q;
      end else if (sr_rd_sel == CSRF_SR_MASK) begin
        sr_rd_data_q <= {31'h0000_0000, mask_q};
      end else if (sr_rd_sel == CSRF_SR_SEL) begin
        sr_rd_data_q <= {30'h0000_0000, use_psp, 1'b0}; // RL19
      end else begin
        sr_rd_data_q <= status_view(sr_rd_sel, flags_q, exc_q); // RL11 RL13
      end
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      active_sp_q     <= 32'h0000_0000;
      irq_accept_q    <= 1'b0;
      irq_prio_q      <= 2'h0;
      multi_restart_q <= 1'b0;
      stack_ctx_q     <= 1'b0;
      state_fault_q   <= 1'b0;
    end else if (clk_en) begin
      active_sp_q     <= sp_now; // RL6
      irq_accept_q    <= irq_ok; // RL20
      irq_prio_q      <= irq_prio; // RL16
      multi_restart_q <= exc.enter && multi_busy; // RL18
      stack_ctx_q     <= exc.enter && !booting; // RL17
      state_fault_q   <= exec_attempt && !state_q && !booting; // RL21
    end
  end

  a_thread_after_boot: assert property (@(posedge ref_clk) disable iff (!resetn)
    $rose(boot_q == CSRF_RUN) |-> !handler_mode_q) else $error("not in thread mode after boot"); // RL1
  a_entry_handler: assert property (@(posedge ref_clk) disable iff (!resetn)
    clk_en && exc.enter && !booting |=> handler_mode_q && exc_q == $past(exc.num)) else $error("entry mismatch"); // RL2 RL22
  a_push_dec: assert property (@(posedge ref_clk) disable iff (!resetn) // RL3
    clk_en && stack_push && !stack_pop && !booting && !use_psp && !msp_sw |=> msp_q == $past(msp_q) - STACK_WORD)
    else $error("push did not decrement");
  // output path, not only the select, must follow the main pointer
  a_handler_msp: assert property (@(posedge ref_clk) disable iff (!resetn) // RL6
    clk_en && handler_mode_q |=> active_sp_q == $past(msp_q))
    else $error("handler not on main stack");
  a_psp_hold: assert property (@(posedge ref_clk) disable iff (!resetn)
    clk_en && !psp_sw && !(use_psp && (stack_push || stack_pop)) |=> $stable(psp_q)) else $error("psp moved"); // RL23 RL4
  a_sel_ignored: assert property (@(posedge ref_clk) disable iff (!resetn)
    clk_en && handler_mode_q && sr_sel && !exc.ret |=> $stable(sel_q)) else $error("select written in handler"); // RL19
  a_exc_sw_fixed: assert property (@(posedge ref_clk) disable iff (!resetn)
    clk_en && sr_wr.valid && !exc.enter && !exc.ret |=> $stable(exc_q)) else $error("software changed exception"); // RL12
  // stack pointer reads may carry any bit 24, so every view except MSP and PSP is held to zero
  a_state_reads_zero: assert property (@(posedge ref_clk) disable iff (!resetn) // RL13
    clk_en && sr_rd_sel != CSRF_SR_MSP && sr_rd_sel != CSRF_SR_PSP |=> !sr_rd_data_q[STATE_BIT])
    else $error("state bit visible");
  a_mask_blocks: assert property (@(posedge ref_clk) disable iff (!resetn)
    clk_en && mask_q |=> !irq_accept_q) else $error("masked irq accepted"); // RL20
  a_thread_clears: assert property (@(posedge ref_clk) disable iff (!resetn) // RL22 RL2
    clk_en && exc.ret && exc.ret_to_thread && !exc.enter |=> exc_q == EXC_THREAD && !handler_mode_q)
    else $error("return did not clear");
  a_boot_msp_load: assert property (@(posedge ref_clk) disable iff (!resetn) // RL7
    clk_en && msp_boot |=> msp_q == $past(mem_rdata)) else $error("main sp not loaded from vector");
  a_boot_pc_load: assert property (@(posedge ref_clk) disable iff (!resetn) // RL8
    clk_en && boot_q == CSRF_BOOT_PC && mem_rd_ok |=>
      pc_q == {$past(mem_rdata[31:1]), 1'b0} && state_q == $past(mem_rdata[0]))
    else $error("reset vector not loaded");
endmodule
`default_nettype wire

// ==== csrf_tb.sv ====
`timescale 1ns/10ps
`default_nettype none
module testbench
  import csrf_pkg::*;
;
  typedef struct packed {logic [3:0] i; logic [31:0] d; logic [31:0] e;} csrf_tb_gp_t;
  typedef struct packed {csrf_sreg_t s; logic [31:0] d; logic [31:0] e;} csrf_tb_sr_t;
  localparam logic [31:0] SP0 = 32'h2000_1000;
  localparam logic [31:0] PC0 = 32'h0000_0101;
  localparam logic [31:0] PSP1 = 32'h1000_0010;
  localparam logic [31:0] MSP1 = 32'h2000_0800;

  logic        ref_clk, resetn, clk_en, mem_rd_ok, pc_load, state_load, state_val, flags_wr;
  logic        stack_push, stack_pop, irq_req, multi_busy, exec_attempt;
  logic [31:0] mem_rdata, pc_val;
  logic [3:0]  gp_rd_idx;
  logic [1:0]  irq_prio;
  csrf_gpw_t   gp_wr;
  csrf_flags_t flags_val;
  csrf_srw_t   sr_wr;
  csrf_sreg_t  sr_rd_sel;
  csrf_exc_t   exc;
  logic        mem_rd_q, handler_mode_q, irq_accept_q, multi_restart_q, stack_ctx_q, state_fault_q;
  logic [31:0] mem_addr_q, gp_rd_data_q, sr_rd_data_q, active_sp_q, pc_q;
  logic [1:0]  irq_prio_q;
  int          n_fail;
  int          n_compared;

  csrf_tb_gp_t gp_rows [5] = '{
    '{4'h0, 32'hA5A5_0001, 32'hA5A5_0001}, '{4'hC, 32'h5A5A_000C, 32'h5A5A_000C},
    '{4'hE, 32'h0000_1235, 32'h0000_1235}, '{4'hD, 32'hDEAD_0000, SP0},
    '{4'hF, 32'h0000_0301, 32'h0000_0300}};
  csrf_tb_sr_t sr_rows [10] = '{
    '{CSRF_SR_MASK, 32'h1, 32'h1}, '{CSRF_SR_FLAGS, 32'hFFFF_FFFF, 32'hF000_0000},
    '{CSRF_SR_STATUS, 32'h0F00_003F, 32'h0}, '{CSRF_SR_FLAGS_EXC, 32'hA000_0005, 32'hA000_0000},
    '{CSRF_SR_FLAGS_STATE, 32'h5100_0000, 32'h5000_0000}, '{CSRF_SR_EXC_STATE, 32'hFFFF_FFFF, 32'h0},
    '{CSRF_SR_STATE, 32'hFFFF_FFFF, 32'h0}, '{CSRF_SR_PSP, 32'h1000_0013, PSP1},
    '{CSRF_SR_MSP, MSP1, MSP1}, '{CSRF_SR_SEL, 32'h2, 32'h2}};
  logic [5:0]  codes [7] = '{EXC_NMI, EXC_FAULT, EXC_SVC, EXC_PEND, EXC_TICK, EXC_IRQ_LO, EXC_IRQ_HI};

  csrf_core_state csrf_core_state_inst (
    .ref_clk(ref_clk), .resetn(resetn), .clk_en(clk_en), .mem_rd_q(mem_rd_q), .mem_addr_q(mem_addr_q),
    .mem_rd_ok(mem_rd_ok), .mem_rdata(mem_rdata), .gp_wr(gp_wr), .gp_rd_idx(gp_rd_idx),
    .gp_rd_data_q(gp_rd_data_q), .pc_load(pc_load), .pc_val(pc_val), .state_load(state_load),
    .state_val(state_val), .flags_wr(flags_wr), .flags_val(flags_val), .sr_wr(sr_wr),
    .sr_rd_sel(sr_rd_sel), .sr_rd_data_q(sr_rd_data_q), .stack_push(stack_push), .stack_pop(stack_pop),
    .exc(exc), .irq_req(irq_req), .irq_prio(irq_prio), .multi_busy(multi_busy),
    .exec_attempt(exec_attempt), .handler_mode_q(handler_mode_q), .active_sp_q(active_sp_q),
    .pc_q(pc_q), .irq_accept_q(irq_accept_q), .irq_prio_q(irq_prio_q),
    .multi_restart_q(multi_restart_q), .stack_ctx_q(stack_ctx_q), .state_fault_q(state_fault_q));

  always #50 ref_clk = ~ref_clk;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic summarize();
    $display("compared=%0d failed=%0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic sr_w(input csrf_sreg_t s, input logic [31:0] d);
    @(negedge ref_clk);
    sr_wr = '{1'h1, s, d};
    @(negedge ref_clk);
    sr_wr.valid = 1'h0;
  endtask

  task automatic sr_chk(input csrf_sreg_t s, input logic [31:0] e);
    sr_rd_sel = s;
    @(negedge ref_clk);
    chk(sr_rd_data_q, e);
  endtask

  task automatic exc_pulse(input csrf_exc_t v);
    @(negedge ref_clk);
    exc = v;
    @(negedge ref_clk);
    exc = '0;
  endtask

  task automatic push_one();
    @(negedge ref_clk);
    stack_push = 1'h1;
    @(negedge ref_clk);
    stack_push = 1'h0;
    @(negedge ref_clk);
  endtask

  initial begin
    #(2000 * 100);
    n_fail++;
    summarize();
  end

  initial begin
    {ref_clk, resetn, mem_rd_ok, pc_load, state_load, state_val, flags_wr} = '0;
    {stack_push, stack_pop, irq_req, multi_busy, exec_attempt, irq_prio, gp_rd_idx} = '0;
    {mem_rdata, pc_val, gp_wr, flags_val, sr_wr, exc} = '0;
    sr_rd_sel = CSRF_SR_STATUS;
    clk_en = 1'h1;
    n_fail = 0;
    n_compared = 0;
    repeat (20) @(negedge ref_clk);
    resetn = 1'h1;
    @(negedge ref_clk);
    chk(32'(mem_rd_q), 32'h1);
    chk(mem_addr_q, VEC_STACK_ADDR);
    mem_rdata = SP0;
    mem_rd_ok = 1'h1;
    @(negedge ref_clk);
    chk(mem_addr_q, VEC_RESET_ADDR);
    mem_rdata = PC0;
    @(negedge ref_clk);
    chk(active_sp_q, SP0);
    mem_rd_ok = 1'h0;
    mem_rdata = 32'hFFFF_FFFF;
    chk(32'(mem_rd_q), 32'h0);
    chk(pc_q, 32'h0000_0100);
    chk(32'(handler_mode_q), 32'h0);
    exec_attempt = 1'h1;
    @(negedge ref_clk);
    exec_attempt = 1'h0;
    chk(32'(state_fault_q), 32'h0);
    $display("test boot done");

    foreach (gp_rows[k]) begin
      @(negedge ref_clk);
      gp_wr = '{1'h1, gp_rows[k].i, gp_rows[k].d};
      @(negedge ref_clk);
      gp_wr.valid = 1'h0;
      gp_rd_idx = gp_rows[k].i;
      @(negedge ref_clk);
      chk(gp_rd_data_q, gp_rows[k].e);
    end
    foreach (sr_rows[k]) begin
      sr_w(sr_rows[k].s, sr_rows[k].d);
      sr_chk(sr_rows[k].s, sr_rows[k].e);
    end
    $display("test table done");

    chk(active_sp_q, PSP1);
    push_one();
    chk(active_sp_q, PSP1 - STACK_WORD);
    sr_chk(CSRF_SR_MSP, MSP1);
    $display("test thread stack done");

    multi_busy = 1'h1;
    exc_pulse('{1'h1, EXC_SVC, 32'h0000_0401, 1'h0, 1'h0, 1'h0});
    multi_busy = 1'h0;
    chk(32'(handler_mode_q), 32'h1);
    chk(32'(stack_ctx_q), 32'h1);
    chk(32'(multi_restart_q), 32'h1);
    sr_chk(CSRF_SR_EXC, {26'h0, EXC_SVC});
    chk(active_sp_q, MSP1);
    chk(32'(stack_ctx_q), 32'h0);
    sr_chk(CSRF_SR_SEL, 32'h0);
    sr_w(CSRF_SR_SEL, 32'h2);
    sr_chk(CSRF_SR_SEL, 32'h0);
    chk(active_sp_q, MSP1);
    push_one();
    chk(active_sp_q, MSP1 - STACK_WORD);
    sr_chk(CSRF_SR_PSP, PSP1 - STACK_WORD);
    foreach (codes[k]) begin
      exc_pulse('{1'h1, codes[k], 32'h0000_0401, 1'h0, 1'h0, 1'h0});
      sr_chk(CSRF_SR_EXC, {26'h0, codes[k]});
    end
    exc_pulse('{1'h0, 6'h0, 32'h0, 1'h1, 1'h1, 1'h1});
    chk(32'(handler_mode_q), 32'h0);
    sr_chk(CSRF_SR_EXC, 32'h0);
    chk(active_sp_q, PSP1 - STACK_WORD);
    $display("test exception done");

    @(negedge ref_clk);
    irq_req = 1'h1;
    irq_prio = 2'h3;
    @(negedge ref_clk);
    chk(32'(irq_accept_q), 32'h0);
    sr_w(CSRF_SR_MASK, 32'h0);
    for (int p = 0; p < PRIO_LEVELS; p++) begin
      irq_prio = 2'(p);
      @(negedge ref_clk);
      chk(32'(irq_accept_q), 32'h1);
      chk(32'(irq_prio_q), 32'(p));
    end
    irq_req = 1'h0;
    $display("test mask done");

    flags_wr = 1'h1;
    flags_val = '{1'h1, 1'h0, 1'h0, 1'h1};
    @(negedge ref_clk);
    flags_wr = 1'h0;
    sr_chk(CSRF_SR_FLAGS, 32'h9000_0000);
    state_load = 1'h1;
    @(negedge ref_clk);
    state_load = 1'h0;
    exec_attempt = 1'h1;
    @(negedge ref_clk);
    exec_attempt = 1'h0;
    chk(32'(state_fault_q), 32'h1);
    sr_chk(CSRF_SR_STATUS, 32'h9000_0000);
    $display("test flags and state done");

    clk_en = 1'h0;
    stack_push = 1'h1;
    exec_attempt = 1'h1;
    @(negedge ref_clk);
    stack_push = 1'h0;
    exec_attempt = 1'h0;
    clk_en = 1'h1;
    chk(32'(state_fault_q), 32'h0);
    pc_load = 1'h1;
    pc_val = 32'h0000_0207;
    sr_chk(CSRF_SR_PSP, PSP1 - STACK_WORD);
    pc_load = 1'h0;
    chk(pc_q, 32'h0000_0206);
    $display("test hold and branch done");

    exc_pulse('{1'h1, EXC_TICK, 32'h0000_0401, 1'h0, 1'h0, 1'h0});
    resetn = 1'h0;
    @(negedge ref_clk);
    chk(32'(handler_mode_q), 32'h0);
    chk(32'(mem_rd_q), 32'h1);
    chk(mem_addr_q, VEC_STACK_ADDR);
    resetn = 1'h1;
    @(negedge ref_clk);
    chk(32'(mem_rd_q), 32'h1);
    chk(mem_addr_q, VEC_STACK_ADDR);
    $display("test second reset done");
    summarize();
  end
endmodule
`default_nettype wire
